/* logic/rcio_pkg.sv */
// constants for the remote contact i/o block
`default_nettype none
package rcio_pkg;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STANDBY  = 8'h04;
  localparam logic [7:0] OFS_THRESH   = 8'h08;
  localparam logic [7:0] OFS_SETPOINT = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
  // control fields
  localparam int CTRL_REMOTE   = 0;
  localparam int CTRL_TEMP_MDL = 1;
  localparam int CTRL_SPD_ONLY = 2;
  localparam int CTRL_UPTO_SB  = 3;
  localparam int CTRL_W        = 4;
  // status / interrupt fields
  localparam int EV_OK_CHG  = 0;
  localparam int EV_ROT_CHG = 1;
  localparam int EV_WARN    = 2;
  localparam int EV_FAULT   = 3;
  localparam int EV_W       = 4;
  // reset values and limits
  localparam logic [3:0]  CTRL_RST     = 4'h0;
  localparam logic [15:0] STANDBY_MIN  = 16'h3A98;
  localparam logic [15:0] STANDBY_RST  = 16'h3A98;
  localparam logic [7:0]  THRESH_MIN   = 8'hFD;
  localparam logic [7:0]  THRESH_MAX   = 8'h32;
  localparam logic [7:0]  THRESH_RST   = 8'hFD;
  localparam logic [7:0]  SETPOINT_RST = 8'h1E;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
  // process values
  localparam logic [15:0] ROT_MIN_RPM  = 16'h0064;
  localparam logic [7:0]  TEMP_MARGIN  = 8'h03;
  localparam logic [7:0]  PCT_BASE     = 8'h64;
  localparam logic [23:0] PCT_DIV      = 24'h00_0064;
  // timing
  localparam int CLK_MHZ      = 50;
  localparam int DEBOUNCE_US  = 10000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
endpackage
`default_nettype wire

/* logic/rcio_remote_contact.sv */
// remote contact inputs and status contact outputs of the pump drive
// ==========================================================================
// Function
// - purge contact closed drives purge valve
// - vent contact closed drives air inlet valve
// - standby contact selects standby speed target
// - run contact closed starts, open stops pump
// - inputs act only in hardware-remote mode
// - plain model: ok when speed reaches threshold
// - regulated model also needs temperature >= setpoint-3
// - at-speed-only option ignores temperature
// - rotation closed while speed above 100 rpm
// - warning contact opens while warning present
// - fault contact opens while fault present
// - upto-standby option opens ok above standby speed while standby is selected in remote mode
// - threshold -3..50 percent, reset -3
// - standby speed 15000..nominal, reset 15000
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// contact debouncer
module rcio_debounce #(
  parameter int CYC = rcio_pkg::DEBOUNCE_CYC
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic raw_i,
  output logic      level_o
);
  logic        s1_r;
  logic        s2_r;
  logic [31:0] cnt_r;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end
    else
    begin
      s1_r <= raw_i;
      s2_r <= s1_r;
    end
  end

  // level taken only after it stood stable for CYC cycles
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r   <= 32'h0000_0000;
      level_o <= 1'b0;
    end
    else if (s2_r == level_o)
      cnt_r <= 32'h0000_0000;
    else if (cnt_r >= 32'(CYC - 1))
    begin
      cnt_r   <= 32'h0000_0000;
      level_o <= s2_r;
    end
    else
      cnt_r <= cnt_r + 32'h0000_0001;
  end
endmodule

// ==========================================================================
// top
module rcio_remote_contact #(
  parameter int          DEBOUNCE_CYC = rcio_pkg::DEBOUNCE_CYC,
  parameter logic [15:0] NOMINAL_RPM  = 16'h7530
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rd_data_o,
  input  wire logic        purge_input_i,
  input  wire logic        vent_input_i,
  input  wire logic        standby_select_input_i,
  input  wire logic        run_stop_input_i,
  input  wire logic [15:0] speed_rpm_i,
  input  wire logic [7:0]  temp_c_i,
  input  wire logic        warning_i,
  input  wire logic        fault_i,
  output logic             purge_valve_o,
  output logic             vent_valve_o,
  output logic             run_o,
  output logic      [15:0] target_rpm_o,
  output logic             ok_process_o,
  output logic             rotation_o,
  output logic             warning_contact_o,
  output logic             fault_contact_o,
  output logic             irq_o
);
  logic [3:0]  ctrl_r;
  logic [15:0] standby_r;
  logic [7:0]  thresh_r;
  logic [7:0]  setpoint_r;
  logic [3:0]  irq_stat_r;
  logic [3:0]  irq_mask_r;
  logic [15:0] thr_rpm_r;
  logic [3:0]  ev_nxt;
  logic        purge_db;
  logic        vent_db;
  logic        standby_db;
  logic        run_db;
  logic        remote;
  logic        spd_ok;
  logic        temp_ok;
  logic        ok_nxt;
  logic [23:0] thr_prod;

  // ========================================================================
  // contact inputs
  rcio_debounce #(.CYC(DEBOUNCE_CYC)) u_db_purge (
    .clk_i(clk_i), .rst_i(rst_i), .raw_i(purge_input_i), .level_o(purge_db));
  rcio_debounce #(.CYC(DEBOUNCE_CYC)) u_db_vent (
    .clk_i(clk_i), .rst_i(rst_i), .raw_i(vent_input_i), .level_o(vent_db));
  rcio_debounce #(.CYC(DEBOUNCE_CYC)) u_db_standby (
    .clk_i(clk_i), .rst_i(rst_i), .raw_i(standby_select_input_i), .level_o(standby_db));
  rcio_debounce #(.CYC(DEBOUNCE_CYC)) u_db_run (
    .clk_i(clk_i), .rst_i(rst_i), .raw_i(run_stop_input_i), .level_o(run_db));

  assign remote = ctrl_r[rcio_pkg::CTRL_REMOTE];

  // ========================================================================
  // register writes
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_r     <= rcio_pkg::CTRL_RST;
      standby_r  <= rcio_pkg::STANDBY_RST;
      thresh_r   <= rcio_pkg::THRESH_RST;
      setpoint_r <= rcio_pkg::SETPOINT_RST;
      irq_mask_r <= rcio_pkg::IRQ_MASK_RST;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        rcio_pkg::OFS_CTRL:     ctrl_r     <= wr_data_i[3:0];
        rcio_pkg::OFS_STANDBY:
          if (wr_data_i < rcio_pkg::STANDBY_MIN)
            standby_r <= rcio_pkg::STANDBY_MIN;
          else if (wr_data_i > NOMINAL_RPM)
            standby_r <= NOMINAL_RPM;
          else
            standby_r <= wr_data_i;
        rcio_pkg::OFS_THRESH:
          if ($signed(wr_data_i[7:0]) < $signed(rcio_pkg::THRESH_MIN))
            thresh_r <= rcio_pkg::THRESH_MIN;
          else if ($signed(wr_data_i[7:0]) > $signed(rcio_pkg::THRESH_MAX))
            thresh_r <= rcio_pkg::THRESH_MAX;
          else
            thresh_r <= wr_data_i[7:0];
        rcio_pkg::OFS_SETPOINT: setpoint_r <= wr_data_i[7:0];
        rcio_pkg::OFS_IRQ_MASK: irq_mask_r <= wr_data_i[3:0];
        default:                ;
      endcase
    end
  end

  // ========================================================================
  // register reads, data valid the cycle after the strobe only
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rd_data_o <= 16'h0000;
    else if (rd_i)
    begin
      unique case (addr_i)
        rcio_pkg::OFS_CTRL:     rd_data_o <= {12'h000, ctrl_r};
        rcio_pkg::OFS_STANDBY:  rd_data_o <= standby_r;
        rcio_pkg::OFS_THRESH:   rd_data_o <= {8'h00, thresh_r};
        rcio_pkg::OFS_SETPOINT: rd_data_o <= {8'h00, setpoint_r};
        rcio_pkg::OFS_STATUS:   rd_data_o <= {6'h00, fault_contact_o, warning_contact_o,
                                              rotation_o, ok_process_o, run_o, vent_valve_o,
                                              purge_valve_o, standby_db & remote, run_db, 1'b0};
        rcio_pkg::OFS_IRQ_STAT: rd_data_o <= {12'h000, irq_stat_r};
        rcio_pkg::OFS_IRQ_MASK: rd_data_o <= {12'h000, irq_mask_r};
        default:                rd_data_o <= 16'h0000;
      endcase
    end
    else
      rd_data_o <= 16'h0000;
  end

  // ========================================================================
  // remote commands
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      purge_valve_o <= 1'b0;
      vent_valve_o  <= 1'b0;
      run_o         <= 1'b0;
      target_rpm_o  <= NOMINAL_RPM;
    end
    else
    begin
      purge_valve_o <= remote & purge_db;
      vent_valve_o  <= remote & vent_db;
      run_o         <= remote & run_db;
      target_rpm_o  <= (remote & standby_db) ? standby_r : NOMINAL_RPM;
    end
  end

  // ========================================================================
  // status contacts
  assign thr_prod = 24'(NOMINAL_RPM) * 24'(8'(rcio_pkg::PCT_BASE + thresh_r)); // 8-bit sum wraps

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      thr_rpm_r <= 16'(24'(NOMINAL_RPM) * 24'(8'(rcio_pkg::PCT_BASE + rcio_pkg::THRESH_RST))
                       / rcio_pkg::PCT_DIV);
    else
      thr_rpm_r <= 16'(thr_prod / rcio_pkg::PCT_DIV);
  end

  always_comb
  begin
    spd_ok  = speed_rpm_i >= thr_rpm_r;
    temp_ok = ({1'b0, temp_c_i} + {1'b0, rcio_pkg::TEMP_MARGIN}) >= {1'b0, setpoint_r};
    if (ctrl_r[rcio_pkg::CTRL_TEMP_MDL] && !ctrl_r[rcio_pkg::CTRL_SPD_ONLY])
      ok_nxt = spd_ok & temp_ok;
    else
      ok_nxt = spd_ok;
    if (ctrl_r[rcio_pkg::CTRL_UPTO_SB] && remote && standby_db && speed_rpm_i > standby_r)
      ok_nxt = 1'b0;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ok_process_o      <= 1'b0;
      rotation_o        <= 1'b0;
      warning_contact_o <= 1'b0;
      fault_contact_o   <= 1'b0;
    end
    else
    begin
      ok_process_o      <= ok_nxt;
      rotation_o        <= speed_rpm_i > rcio_pkg::ROT_MIN_RPM;
      warning_contact_o <= ~warning_i;
      fault_contact_o   <= ~fault_i;
    end
  end

  // ========================================================================
  // interrupts: sticky status, write one to clear, set wins
  always_comb
  begin
    ev_nxt                       = 4'h0;
    ev_nxt[rcio_pkg::EV_OK_CHG]  = ok_nxt != ok_process_o;
    ev_nxt[rcio_pkg::EV_ROT_CHG] = (speed_rpm_i > rcio_pkg::ROT_MIN_RPM) != rotation_o;
    ev_nxt[rcio_pkg::EV_WARN]    = warning_i & warning_contact_o;
    ev_nxt[rcio_pkg::EV_FAULT]   = fault_i & fault_contact_o;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_stat_r <= 4'h0;
    else if (wr_i && addr_i == rcio_pkg::OFS_IRQ_STAT)
      irq_stat_r <= (irq_stat_r & ~wr_data_i[3:0]) | ev_nxt;
    else
      irq_stat_r <= irq_stat_r | ev_nxt;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |((irq_stat_r | ev_nxt) & irq_mask_r);
  end

  // ========================================================================
  // checks
  a_purge_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (remote && purge_db) |=> purge_valve_o)
    else $error("purge valve not driven");
  a_vent_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    (vent_valve_o |-> $past(vent_db) && $past(remote)))
    else $error("vent valve without command");
  a_standby_target: assert property (@(posedge clk_i) disable iff (rst_i)
    (remote && standby_db) |=> target_rpm_o == $past(standby_r))
    else $error("standby target wrong");
  a_run_cmd: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(run_db) |=> !run_o)
    else $error("pump not stopped");
  a_local_mode_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !remote |=> !purge_valve_o && !vent_valve_o && !run_o && target_rpm_o == NOMINAL_RPM)
    else $error("contact acted outside remote mode");
  a_ok_speed: assert property (@(posedge clk_i) disable iff (rst_i)
    (speed_rpm_i < thr_rpm_r) |=> !ok_process_o)
    else $error("ok without speed");
  a_ok_temp: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_r[1] && !ctrl_r[2] && ({1'b0, temp_c_i} + 9'h003) < {1'b0, setpoint_r})
    |=> !ok_process_o)
    else $error("ok while too cold");
  a_ok_speed_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_r[2] && spd_ok && !(ctrl_r[3] && remote && standby_db && speed_rpm_i > standby_r))
    |=> ok_process_o)
    else $error("speed-only ok missing");
  a_rotation: assert property (@(posedge clk_i) disable iff (rst_i)
    rotation_o == ($past(speed_rpm_i) > 16'h0064))
    else $error("rotation contact wrong");
  a_warn_open: assert property (@(posedge clk_i) disable iff (rst_i)
    warning_i [*2] |-> !warning_contact_o)
    else $error("warning contact closed");
  a_fault_open: assert property (@(posedge clk_i) disable iff (rst_i)
    fault_i ##1 !fault_i |=> fault_contact_o)
    else $error("fault contact stuck open");
  a_upto_standby: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_r[3] && remote && standby_db && speed_rpm_i > standby_r) |=> !ok_process_o)
    else $error("ok above standby speed");
  a_thresh_range: assert property (@(posedge clk_i) disable iff (rst_i)
    $signed(thresh_r) >= -8'sd3 && $signed(thresh_r) <= 8'sd50)
    else $error("threshold out of range");
  a_standby_range: assert property (@(posedge clk_i) disable iff (rst_i)
    standby_r >= 16'h3A98 && standby_r <= NOMINAL_RPM)
    else $error("standby speed out of range");
  a_debounce_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(run_db) |=> $stable(run_db))
    else $error("debounced level toggled twice");

  c_remote_start: cover property (@(posedge clk_i) disable iff (rst_i) $rose(run_o));
  c_purge_on: cover property (@(posedge clk_i) disable iff (rst_i) $rose(purge_valve_o));
  c_ok_rise: cover property (@(posedge clk_i) disable iff (rst_i) $rose(ok_process_o));
  c_irq: cover property (@(posedge clk_i) disable iff (rst_i) $rose(irq_o));
endmodule
`default_nettype wire

/* testbench/rcio_host_contacts.sv */
// host-side contact model driving the four remote inputs
`timescale 1ns/1ns
`default_nettype none
module rcio_host_contacts (
  input  wire logic       clk_i,
  input  wire logic [3:0] cmd_i,
  input  wire logic       bounce_i,
  output var  logic [3:0] con_o
);
  initial con_o = 4'h0;
  // bounce flips every contact each cycle, never steady for long
  always @(posedge clk_i)
  begin
    con_o <= bounce_i ? ~con_o : cmd_i;
  end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// self-checking bench for the remote contact block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {
    logic [3:0]  ctrl;
    logic [3:0]  con;
    logic [15:0] spd;
    logic [7:0]  tmp;
    logic        w;
    logic        f;
    logic [2:0]  ev;
    logic [15:0] tgt;
    logic [3:0]  es;
  } rcio_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [15:0] wr_data_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [15:0] speed = 16'h0000;
  logic [7:0]  temp = 8'h00;
  logic        warn = 1'b0;
  logic        fault = 1'b0;
  logic [3:0]  cmd = 4'h0;
  logic        bounce = 1'b0;
  logic [3:0]  con;
  logic [15:0] rd_data_o;
  logic [15:0] target_rpm_o;
  logic        purge_valve_o, vent_valve_o, run_o, ok_process_o;
  logic        rotation_o, warning_contact_o, fault_contact_o, irq_o;
  int          failures = 0;
  int          compares = 0;
  // ev = {run, vent, purge}, es = {ok, rotation, warning, fault}
  rcio_row_t   rows [9] = '{
    '{4'h0, 4'hF, 16'h71AC, 8'h00, 1'b0, 1'b0, 3'h0, 16'h7530, 4'hF},
    '{4'h1, 4'h1, 16'h71AB, 8'h00, 1'b1, 1'b0, 3'h1, 16'h7530, 4'h5},
    '{4'h1, 4'h2, 16'h0064, 8'h00, 1'b0, 1'b1, 3'h2, 16'h7530, 4'h2},
    '{4'h1, 4'hC, 16'h0065, 8'h00, 1'b0, 1'b0, 3'h4, 16'h3A98, 4'h7},
    '{4'h3, 4'h0, 16'h71AC, 8'h1A, 1'b0, 1'b0, 3'h0, 16'h7530, 4'h7},
    '{4'h3, 4'h0, 16'h71AC, 8'h1B, 1'b0, 1'b0, 3'h0, 16'h7530, 4'hF},
    '{4'h7, 4'h0, 16'h71AC, 8'h00, 1'b0, 1'b0, 3'h0, 16'h7530, 4'hF},
    '{4'h9, 4'h4, 16'h71AC, 8'h00, 1'b0, 1'b0, 3'h0, 16'h3A98, 4'h7},
    '{4'h1, 4'h4, 16'h71AC, 8'h00, 1'b0, 1'b0, 3'h0, 16'h3A98, 4'hF}};

  always #10 clk_i = ~clk_i;

  rcio_host_contacts i_rcio_host_contacts (
    .clk_i    (clk_i),
    .cmd_i    (cmd),
    .bounce_i (bounce),
    .con_o    (con)
  );

  rcio_remote_contact #(.DEBOUNCE_CYC(4), .NOMINAL_RPM(16'h7530)) i_rcio_remote_contact (
    .clk_i (clk_i), .rst_i (rst_i), .addr_i (addr_i), .wr_data_i (wr_data_i),
    .wr_i (wr_i), .rd_i (rd_i), .rd_data_o (rd_data_o),
    .purge_input_i (con[0]), .vent_input_i (con[1]),
    .standby_select_input_i (con[2]), .run_stop_input_i (con[3]),
    .speed_rpm_i (speed), .temp_c_i (temp), .warning_i (warn), .fault_i (fault),
    .purge_valve_o (purge_valve_o), .vent_valve_o (vent_valve_o), .run_o (run_o),
    .target_rpm_o (target_rpm_o), .ok_process_o (ok_process_o),
    .rotation_o (rotation_o), .warning_contact_o (warning_contact_o),
    .fault_contact_o (fault_contact_o), .irq_o (irq_o)
  );

  // ==========================================================================
  // compare, bus and closing tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic g);
    chk(n, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic go(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(n, e, rd_data_o);
  endtask
  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    go(20000);
    failures++;
    conclude();
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    go(1);
    chk("target_in_reset", 16'h7530, target_rpm_o);
    chkb("run_in_reset", 1'b0, run_o);
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd("ctrl_rst", rcio_pkg::OFS_CTRL, 16'h0000);
    rd("standby_rst", rcio_pkg::OFS_STANDBY, 16'h3A98);
    rd("thresh_rst", rcio_pkg::OFS_THRESH, 16'h00FD);
    rd("setpoint_rst", rcio_pkg::OFS_SETPOINT, 16'h001E);
    rd("mask_rst", rcio_pkg::OFS_IRQ_MASK, 16'h0000);
    rd("unmapped", 8'h1C, 16'h0000);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rcio_pkg::OFS_CTRL, {12'h000, rows[i].ctrl});
      cmd <= rows[i].con;
      speed <= rows[i].spd;
      temp <= rows[i].tmp;
      warn <= rows[i].w;
      fault <= rows[i].f;
      go(12);
      chk("commands", {13'h0000, rows[i].ev}, {13'h0000, run_o, vent_valve_o, purge_valve_o});
      chk("target", rows[i].tgt, target_rpm_o);
      chk("contacts", {12'h000, rows[i].es},
          {12'h000, ok_process_o, rotation_o, warning_contact_o, fault_contact_o});
      $display("test row %0d done", i);
    end
    wr(rcio_pkg::OFS_THRESH, 16'h0032);
    cmd <= 4'h0;
    rd("thresh_max", rcio_pkg::OFS_THRESH, 16'h0032);
    @(posedge clk_i);
    speed <= 16'hAFC7;
    go(12);
    chkb("ok_below_50pct", 1'b0, ok_process_o);
    @(posedge clk_i);
    speed <= 16'hAFC8;
    go(3);
    chkb("ok_at_50pct", 1'b1, ok_process_o);
    wr(rcio_pkg::OFS_THRESH, 16'h0050);
    rd("thresh_clamp_hi", rcio_pkg::OFS_THRESH, 16'h0032);
    wr(rcio_pkg::OFS_THRESH, 16'h00F0);
    rd("thresh_clamp_lo", rcio_pkg::OFS_THRESH, 16'h00FD);
    wr(rcio_pkg::OFS_STANDBY, 16'h03E8);
    rd("standby_clamp_lo", rcio_pkg::OFS_STANDBY, 16'h3A98);
    wr(rcio_pkg::OFS_STANDBY, 16'hFFFF);
    rd("standby_clamp_hi", rcio_pkg::OFS_STANDBY, 16'h7530);
    $display("test limits done");
    @(posedge clk_i);
    bounce <= 1'b1;
    for (int k = 0; k < 20; k++)
    begin
      go(1);
      chk("bounce_commands", 16'h0000, {13'h0000, run_o, vent_valve_o, purge_valve_o});
    end
    @(posedge clk_i);
    bounce <= 1'b0;
    $display("test bounce done");
    wr(rcio_pkg::OFS_IRQ_STAT, 16'h000F);
    rd("irq_cleared", rcio_pkg::OFS_IRQ_STAT, 16'h0000);
    @(posedge clk_i);
    fault <= 1'b1;
    go(3);
    chkb("irq_masked", 1'b0, irq_o);
    chkb("fault_opens", 1'b0, fault_contact_o);
    rd("irq_fault_set", rcio_pkg::OFS_IRQ_STAT, 16'h0008);
    wr(rcio_pkg::OFS_IRQ_MASK, 16'h0008);
    go(2);
    chkb("irq_unmasked", 1'b1, irq_o);
    @(posedge clk_i);
    wr(rcio_pkg::OFS_IRQ_STAT, 16'h0008);
    go(2);
    chkb("irq_after_clear", 1'b0, irq_o);
    rd("status", rcio_pkg::OFS_STATUS, 16'h01C0);
    $display("test interrupt done");
    conclude();
  end
endmodule
`default_nettype wire
